// >>> inc/sp_cfg_pkg.sv
// constants and field layout for the serial port configuration bank
//----------------------------------------------------------------------
// What this block does
// - second port activate resets to zero
// - first port activate resets to zero
// - base high bits 7-3 read zero
// - base low bits 2-0 read zero
// - irq number resets 03h second, 04h first
// - irq type: only bit 1 writable
// - second port rx/tx dma selects reset 04h
// - first port dma reads fixed 04h
// - config register resets to 02h
// - bank enable gates extended register access
// - busy bit read-only, set during transfer
// - power bit low stops clock, defaults outputs
// - call indicator still interrupts in low power
// - low power keeps registers accessible
// - power bit high runs port clock while the port is active
// - float outputs when inactive and enabled
// - infrared transmit low when second inactive
// - first config same layout, resets 02h
//----------------------------------------------------------------------
package sp_cfg_pkg;
  // register indices
  localparam logic [7:0] IDX_ACTIVATE  = 8'h30;
  localparam logic [7:0] IDX_BASE_HIGH = 8'h60;
  localparam logic [7:0] IDX_BASE_LOW  = 8'h61;
  localparam logic [7:0] IDX_IRQ_WAKE  = 8'h70;
  localparam logic [7:0] IDX_IRQ_KIND  = 8'h71;
  localparam logic [7:0] IDX_DMA_A     = 8'h74;
  localparam logic [7:0] IDX_DMA_B     = 8'h75;
  localparam logic [7:0] IDX_CONFIG    = 8'hF0;
  localparam logic [7:0] IDX_EV_STATUS = 8'hF8;
  localparam logic [7:0] IDX_EV_ENABLE = 8'hF9;
  localparam logic [7:0] IDX_EV_CLEAR  = 8'hFA;
  // reset values
  localparam logic [7:0] RST_ACTIVATE   = 8'h00;
  localparam logic [7:0] RST_BASE_HI_2  = 8'h02;
  localparam logic [7:0] RST_BASE_HI_1  = 8'h03;
  localparam logic [7:0] RST_BASE_LOW   = 8'hF8;
  localparam logic [7:0] RST_IRQ_WAKE_2 = 8'h03;
  localparam logic [7:0] RST_IRQ_WAKE_1 = 8'h04;
  localparam logic [7:0] RST_IRQ_KIND   = 8'h03;
  localparam logic [7:0] DMA_NONE       = 8'h04;
  localparam logic [7:0] RST_CONFIG     = 8'h02;
  // writable masks
  localparam logic [7:0] MASK_BASE_HIGH = 8'h07;
  localparam logic [7:0] MASK_BASE_LOW  = 8'hF8;
  localparam logic [7:0] MASK_IRQ_KIND  = 8'h02;
  localparam logic [7:0] MASK_CONFIG    = 8'h83;
  // config field positions
  localparam int CFG_BANK  = 7;
  localparam int CFG_BUSY  = 2;
  localparam int CFG_POWER = 1;
  localparam int CFG_FLOAT = 0;
  // global register bit positions
  localparam int G1_ENABLE  = 0;
  localparam int G6_SECOND  = 2;
  localparam int G6_FIRST   = 3;
  // event bits: per port call indicator
  localparam int EV_WIDTH = 2;
endpackage

// >>> inc/sp_port_if.sv
// per port signals between the bank and the port gating module
`timescale 1ns/1ps
interface sp_port_if;
  logic       active;    // logical device effectively on
  logic [7:0] config_q;  // stored config register
  logic       clk_run;   // port clock enable
  logic       out_deflt; // outputs forced to idle
  logic       out_float; // outputs released
  modport bank (output active, output config_q, input clk_run, input out_deflt, input out_float);
  modport gate (input active, input config_q, output clk_run, output out_deflt, output out_float);
endinterface

// >>> design/sp_port_gate.sv
// power and float decode for one serial port
`timescale 1ns/1ps
module sp_port_gate
  import sp_cfg_pkg::*;
(
  // link to bank
  sp_port_if.gate port
);
  //--------------------------------------------------------------------
  // decode
  //--------------------------------------------------------------------
  // clock stops in low power
  assign port.clk_run   = port.active & port.config_q[CFG_POWER];
  assign port.out_deflt = ~port.clk_run;
  assign port.out_float = ~port.active & port.config_q[CFG_FLOAT];
endmodule // sp_port_gate

// >>> design/sp_cfg_bank.sv
// configuration register bank for two serial port logical devices
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module sp_cfg_bank
  import sp_cfg_pkg::*;
(
  // clock and reset
  input  wire logic       REF_CLK,
  input  wire logic       RESET_N,
  // register port
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  input  wire logic       PORT_SEL,   // 1 selects the first port, 0 the second
  output logic      [7:0] RDATA,
  // global qualifiers
  input  wire logic [7:0] GLOBAL_CONFIG_REG_ONE,
  input  wire logic [7:0] GLOBAL_CONFIG_REG_SIX,
  // port status inputs
  input  wire logic       SECOND_BUSY,
  input  wire logic       FIRST_BUSY,
  input  wire logic       SECOND_CALL_IND_N,
  input  wire logic       FIRST_CALL_IND_N,
  input  wire logic       SECOND_EXT_REQ,
  input  wire logic       FIRST_EXT_REQ,
  // port controls
  output logic            SECOND_CLK_RUN,
  output logic            FIRST_CLK_RUN,
  output logic            SECOND_OUT_DEFAULT,
  output logic            FIRST_OUT_DEFAULT,
  output logic            SECOND_OUT_FLOAT,
  output logic            FIRST_OUT_FLOAT,
  output logic            SECOND_EXT_GRANT,
  output logic            FIRST_EXT_GRANT,
  output logic            SECOND_REG_ACCESS,
  output logic            FIRST_REG_ACCESS,
  output logic            INFRARED_TRANSMIT_OUT_FORCE_LOW,
  // interrupt
  output logic            IRQ
);
  //--------------------------------------------------------------------
  // storage, index 0 is the second port, 1 the first
  //--------------------------------------------------------------------
  logic [7:0] activate [2];   // activation registers
  logic [7:0] base_high [2];  // base address high bytes
  logic [7:0] base_low [2];   // base address low bytes
  logic [7:0] irq_wake [2];   // irq number and wake enable
  logic [7:0] irq_kind [2];   // irq type
  logic [7:0] config_q [2];   // port configuration
  logic [7:0] rx_dma;         // second port receive dma
  logic [7:0] tx_dma;         // second port transmit dma
  logic [EV_WIDTH-1:0] ev_status; // sticky call indicator events
  logic [EV_WIDTH-1:0] ev_enable; // event enables
  logic [7:0] rdata_q;        // read data register
  // synchronisers for pin inputs
  logic [1:0] busy_meta, busy_sync;
  logic [1:0] call_meta, call_sync, call_last;
  logic [1:0] ext_meta, ext_sync;
  // registered outputs
  logic [1:0] clk_run_q, deflt_q, float_q, grant_q, access_q;
  logic       ir_low_q;
  logic       irq_q;

  //--------------------------------------------------------------------
  // per port decode through the gate module
  //--------------------------------------------------------------------
  logic [1:0] port_active;    // effective activation
  logic [1:0] clk_run_w, deflt_w, float_w;
  logic [1:0] g6_bit;
  assign g6_bit = {GLOBAL_CONFIG_REG_SIX[G6_FIRST], GLOBAL_CONFIG_REG_SIX[G6_SECOND]};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_port
      sp_port_if pif ();
      assign port_active[gi] = activate[gi][0] & GLOBAL_CONFIG_REG_ONE[G1_ENABLE]
                               & g6_bit[gi];
      assign pif.active   = port_active[gi];
      assign pif.config_q = config_q[gi];
      assign clk_run_w[gi] = pif.clk_run;
      assign deflt_w[gi]   = pif.out_deflt;
      assign float_w[gi]   = pif.out_float;
      sp_port_gate u_gate (.port(pif));
    end
  endgenerate

  //--------------------------------------------------------------------
  // address decode
  //--------------------------------------------------------------------
  logic       sel;            // port index of this access
  logic       hit_act, hit_bh, hit_bl, hit_iw, hit_ik, hit_da, hit_db, hit_cfg;
  logic       hit_st, hit_en, hit_clr;
  assign sel     = PORT_SEL;
  assign hit_act = (ADDR == IDX_ACTIVATE);
  assign hit_bh  = (ADDR == IDX_BASE_HIGH);
  assign hit_bl  = (ADDR == IDX_BASE_LOW);
  assign hit_iw  = (ADDR == IDX_IRQ_WAKE);
  assign hit_ik  = (ADDR == IDX_IRQ_KIND);
  assign hit_da  = (ADDR == IDX_DMA_A);
  assign hit_db  = (ADDR == IDX_DMA_B);
  assign hit_cfg = (ADDR == IDX_CONFIG);
  assign hit_st  = (ADDR == IDX_EV_STATUS);
  assign hit_en  = (ADDR == IDX_EV_ENABLE);
  assign hit_clr = (ADDR == IDX_EV_CLEAR);

  // config read view with live busy bit
  logic [7:0] cfg_view [2];
  assign cfg_view[0] = (config_q[0] & MASK_CONFIG) | {5'h00, busy_sync[0], 2'h0};
  assign cfg_view[1] = (config_q[1] & MASK_CONFIG) | {5'h00, busy_sync[1], 2'h0};

  // read mux; unmapped reads return zero
  logic [7:0] next_rdata;
  assign next_rdata =
    hit_act ? activate[sel] :
    hit_bh  ? base_high[sel] :
    hit_bl  ? base_low[sel] :
    hit_iw  ? irq_wake[sel] :
    hit_ik  ? irq_kind[sel] :
    hit_da  ? (sel ? DMA_NONE : rx_dma) :
    hit_db  ? (sel ? DMA_NONE : tx_dma) :
    hit_cfg ? cfg_view[sel] :
    hit_st  ? {6'h00, ev_status} :
    hit_en  ? {6'h00, ev_enable} : 8'h00;

  //--------------------------------------------------------------------
  // pin synchronisers
  //--------------------------------------------------------------------
  // two stages before any use of pin levels
  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      busy_meta <= 2'h0;
      busy_sync <= 2'h0;
      call_meta <= 2'h0;
      call_sync <= 2'h0;
      call_last <= 2'h0;
      ext_meta  <= 2'h0;
      ext_sync  <= 2'h0;
    end
    else
    begin
      busy_meta <= {FIRST_BUSY, SECOND_BUSY};
      busy_sync <= busy_meta;
      call_meta <= {~FIRST_CALL_IND_N, ~SECOND_CALL_IND_N};
      call_sync <= call_meta;
      call_last <= call_sync;
      ext_meta  <= {FIRST_EXT_REQ, SECOND_EXT_REQ};
      ext_sync  <= ext_meta;
    end
  end

  //--------------------------------------------------------------------
  // register writes
  //--------------------------------------------------------------------
  logic wr_ok;                // write qualified
  assign wr_ok = WR & ~RD;

  // storage of both port register sets
  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      activate[0]  <= RST_ACTIVATE;
      activate[1]  <= RST_ACTIVATE;
      base_high[0] <= RST_BASE_HI_2;
      base_high[1] <= RST_BASE_HI_1;
      base_low[0]  <= RST_BASE_LOW;
      base_low[1]  <= RST_BASE_LOW;
      irq_wake[0]  <= RST_IRQ_WAKE_2;
      irq_wake[1]  <= RST_IRQ_WAKE_1;
      irq_kind[0]  <= RST_IRQ_KIND;
      irq_kind[1]  <= RST_IRQ_KIND;
      config_q[0]  <= RST_CONFIG;
      config_q[1]  <= RST_CONFIG;
      rx_dma       <= DMA_NONE;
      tx_dma       <= DMA_NONE;
    end
    else if (wr_ok)
    begin
      // writes never gated by power mode
      if (hit_act)
        activate[sel] <= WDATA;
      if (hit_bh)
        base_high[sel] <= WDATA & MASK_BASE_HIGH;
      if (hit_bl)
        base_low[sel] <= WDATA & MASK_BASE_LOW;
      if (hit_iw)
        irq_wake[sel] <= WDATA;
      if (hit_ik)
        irq_kind[sel] <= (irq_kind[sel] & ~MASK_IRQ_KIND) | (WDATA & MASK_IRQ_KIND);
      if (hit_da && !sel)
        rx_dma <= WDATA;
      if (hit_db && !sel)
        tx_dma <= WDATA;
      if (hit_cfg)
        config_q[sel] <= WDATA & MASK_CONFIG;
    end
  end

  //--------------------------------------------------------------------
  // events and interrupt
  //--------------------------------------------------------------------
  logic [EV_WIDTH-1:0] ev_set;     // call indicator rising edges
  logic [EV_WIDTH-1:0] ev_clr;     // software clear bits
  logic [EV_WIDTH-1:0] next_status;
  // call indicator counted while port active, even in low power
  assign ev_set = call_sync & ~call_last & port_active;
  assign ev_clr = (wr_ok && hit_clr) ? WDATA[EV_WIDTH-1:0] : '0;
  // set beats clear in the same cycle
  assign next_status = (ev_status & ~ev_clr) | ev_set;

  // sticky status and enables
  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ev_status <= '0;
      ev_enable <= '0;
    end
    else
    begin
      ev_status <= next_status;
      if (wr_ok && hit_en)
        ev_enable <= WDATA[EV_WIDTH-1:0];
    end
  end

  //--------------------------------------------------------------------
  // registered outputs
  //--------------------------------------------------------------------
  logic [1:0] bank_en;
  assign bank_en = {config_q[1][CFG_BANK], config_q[0][CFG_BANK]};

  // outputs from flops
  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rdata_q   <= 8'h00;
      clk_run_q <= 2'h0;
      deflt_q   <= 2'h3;
      float_q   <= 2'h0;
      grant_q   <= 2'h0;
      access_q  <= 2'h0;
      ir_low_q  <= 1'b1;
      irq_q     <= 1'b0;
    end
    else
    begin
      rdata_q   <= RD ? next_rdata : 8'h00;
      clk_run_q <= clk_run_w;
      deflt_q   <= deflt_w;
      float_q   <= float_w;
      grant_q   <= ext_sync & bank_en & port_active;
      access_q  <= port_active;
      ir_low_q  <= ~port_active[0];
      irq_q     <= |(next_status & ev_enable);
    end
  end

  assign RDATA              = rdata_q;
  assign SECOND_CLK_RUN     = clk_run_q[0];
  assign FIRST_CLK_RUN      = clk_run_q[1];
  assign SECOND_OUT_DEFAULT = deflt_q[0];
  assign FIRST_OUT_DEFAULT  = deflt_q[1];
  assign SECOND_OUT_FLOAT   = float_q[0];
  assign FIRST_OUT_FLOAT    = float_q[1];
  assign SECOND_EXT_GRANT   = grant_q[0];
  assign FIRST_EXT_GRANT    = grant_q[1];
  assign SECOND_REG_ACCESS  = access_q[0];
  assign FIRST_REG_ACCESS   = access_q[1];
  assign INFRARED_TRANSMIT_OUT_FORCE_LOW = ir_low_q;
  assign IRQ                = irq_q;

  //--------------------------------------------------------------------
  // assertions
  //--------------------------------------------------------------------
  a_base_high_zero: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (base_high[0][7:3] == 5'h00) && (base_high[1][7:3] == 5'h00))
    else $error("base high upper bits not zero");
  a_base_low_align: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (base_low[0][2:0] == 3'h0) && (base_low[1][2:0] == 3'h0))
    else $error("base low not aligned");
  a_kind_fixed_bits: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    wr_ok && hit_ik |=> (irq_kind[$past(sel)] & 8'hFD) == 8'h01)
    else $error("irq type read-only bits changed");
  a_first_dma_none: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    RD && (hit_da || hit_db) && sel |=> RDATA == 8'h04)
    else $error("first port dma not reported empty");
  a_cfg_reserved: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    RD && hit_cfg |=> RDATA[6:3] == 4'h0)
    else $error("config reserved bits not zero");
  a_ext_gate: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    !config_q[0][7] && $stable(config_q[0]) |=> !SECOND_EXT_GRANT)
    else $error("extended access granted while bank disabled");
  a_clock_stop: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    port_active[0] && !config_q[0][1] |=> !SECOND_CLK_RUN && SECOND_OUT_DEFAULT)
    else $error("low power did not stop clock");
  a_float_inactive: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    port_active[1] |=> !FIRST_OUT_FLOAT)
    else $error("active port outputs floated");
  a_ir_low: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    !port_active[0] |=> INFRARED_TRANSMIT_OUT_FORCE_LOW)
    else $error("infrared transmit not held low");
  a_busy_readback: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    RD && hit_cfg && !sel |=> RDATA[2] == $past(busy_sync[0]))
    else $error("busy bit does not track transfer");
endmodule // sp_cfg_bank

// >>> tb/sp_host_model.sv
// host side model issuing configuration register accesses
`timescale 1ns/1ps
module sp_host_model
(
  // clock
  input  wire logic       clk,
  // register port
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            wr,
  output logic            rd,
  output logic            sel,
  input  wire logic [7:0] rdata
);
  //--------------------------------------------------------------------
  // idle bus at time zero
  //--------------------------------------------------------------------
  initial
  begin
    addr  = 8'h00;
    wdata = 8'h00;
    wr    = 1'b0;
    rd    = 1'b0;
    sel   = 1'b0;
  end

  // one cycle write; the slave never stalls, so no ready to wait for
  task automatic wr_reg(input logic s, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sel   <= s;
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, sampled there
  task automatic rd_reg(input logic s, input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sel  <= s;
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d    = rdata;
  endtask
endmodule // sp_host_model

// >>> tb/sp_cfg_bank_tb.sv
// self-checking testbench for the serial port configuration bank
`timescale 1ns/1ps
module sp_cfg_bank_tb;
  //--------------------------------------------------------------------
  // signals
  //--------------------------------------------------------------------
  logic        ref_clk;   // 250 MHz
  logic        reset_n;   // async, active low
  logic [7:0]  addr, wdata, rdata;
  logic        wr, rd, sel;
  logic [7:0]  g_one, g_six;                  // global qualifiers
  logic        s_busy, f_busy, s_ci_n, f_ci_n; // port status pins
  logic        s_ext, f_ext;                  // extended access attempts
  logic [11:0] ctl;        // all control outputs packed together
  int          error_cnt;  // mismatches
  int          n_tests;    // comparisons

  //--------------------------------------------------------------------
  // design and host model
  //--------------------------------------------------------------------
  sp_cfg_bank i_dut (
    .REF_CLK(ref_clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .PORT_SEL(sel), .RDATA(rdata),
    .GLOBAL_CONFIG_REG_ONE(g_one), .GLOBAL_CONFIG_REG_SIX(g_six),
    .SECOND_BUSY(s_busy), .FIRST_BUSY(f_busy),
    .SECOND_CALL_IND_N(s_ci_n), .FIRST_CALL_IND_N(f_ci_n),
    .SECOND_EXT_REQ(s_ext), .FIRST_EXT_REQ(f_ext),
    .SECOND_CLK_RUN(ctl[1]), .FIRST_CLK_RUN(ctl[0]),
    .SECOND_OUT_DEFAULT(ctl[3]), .FIRST_OUT_DEFAULT(ctl[2]),
    .SECOND_OUT_FLOAT(ctl[5]), .FIRST_OUT_FLOAT(ctl[4]),
    .SECOND_EXT_GRANT(ctl[7]), .FIRST_EXT_GRANT(ctl[6]),
    .SECOND_REG_ACCESS(ctl[9]), .FIRST_REG_ACCESS(ctl[8]),
    .INFRARED_TRANSMIT_OUT_FORCE_LOW(ctl[10]), .IRQ(ctl[11])
  );
  sp_host_model i_host (
    .clk(ref_clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .sel(sel), .rdata(rdata)
  );

  //--------------------------------------------------------------------
  // clock, inputs at time zero, overall guard
  //--------------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial
  begin
    reset_n = 1'b0;
    {g_one, g_six} = 16'h0000;
    {s_busy, f_busy, s_ext, f_ext} = 4'h0;
    {s_ci_n, f_ci_n} = 2'b11;  // call indicator idles high
    error_cnt = 0;
    n_tests = 0;
  end
  // a hung run still reaches the verdict
  initial
  begin
    #200000;
    error_cnt++;
    close_out();
  end

  //--------------------------------------------------------------------
  // report and compare tasks
  //--------------------------------------------------------------------
  task automatic close_out;
    $display("errors %0d comparisons %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // register read compared against an expected byte
  task automatic chk(input logic s, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_host.rd_reg(s, a, d);
    n_tests++;
    if (d !== e)
    begin
      error_cnt++;
      $display("unexpected %0t reg %h sel %b read %h want %h", $time, a, s, d, e);
    end
  endtask

  // write then read back
  task automatic wrchk(input logic s, input logic [7:0] a, input logic [7:0] w,
                       input logic [7:0] e);
    i_host.wr_reg(s, a, w);
    chk(s, a, e);
  endtask

  // control outputs settle within a bounded number of cycles
  task automatic wait_ctl(input logic [11:0] m, input logic [11:0] e);
    int n;
    n = 0;
    // step off the launching edge so settled outputs are seen
    #1;
    while (((ctl & m) !== e) && n < 8)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    n_tests++;
    if ((ctl & m) !== e)
    begin
      error_cnt++;
      $display("unexpected %0t controls %h want %h", $time, ctl & m, e);
      close_out();
    end
  endtask

  //--------------------------------------------------------------------
  // main sequence
  //--------------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge ref_clk);
    #1;
    wait_ctl(12'hFFF, 12'h40C);
    chk(1'b0, 8'h00, 8'h00);
    @(posedge ref_clk);
    reset_n <= 1'b1;
    // reset values of both ports
    for (int p = 0; p < 2; p++)
    begin
      chk(p[0], 8'h30, 8'h00);
      chk(p[0], 8'h60, p ? 8'h03 : 8'h02);
      chk(p[0], 8'h61, 8'hF8);
      chk(p[0], 8'h70, p ? 8'h04 : 8'h03);
      chk(p[0], 8'h71, 8'h03);
      chk(p[0], 8'h74, 8'h04);
      chk(p[0], 8'h75, 8'h04);
      chk(p[0], 8'hF0, 8'h02);
    end
    // writable and read-only bits of both ports
    for (int p = 0; p < 2; p++)
    begin
      wrchk(p[0], 8'h30, 8'h01, 8'h01);
      wrchk(p[0], 8'h60, 8'hFF, 8'h07);
      wrchk(p[0], 8'h61, 8'hFF, 8'hF8);
      wrchk(p[0], 8'h61, 8'h07, 8'h00);
      wrchk(p[0], 8'h70, 8'h5A, 8'h5A);
      wrchk(p[0], 8'h71, 8'hFC, 8'h01);
      wrchk(p[0], 8'h71, 8'hFF, 8'h03);
      wrchk(p[0], 8'h74, 8'h01, p ? 8'h04 : 8'h01);
      wrchk(p[0], 8'h75, 8'h02, p ? 8'h04 : 8'h02);
      wrchk(p[0], 8'hF0, 8'hFF, 8'h83);
      wrchk(p[0], 8'hF0, 8'h02, 8'h02);
    end
    // busy flag follows the transfer pins, passing a two flop sync
    @(posedge ref_clk);
    {s_busy, f_busy} <= 2'b11;
    repeat (4) @(posedge ref_clk);
    chk(1'b0, 8'hF0, 8'h06);
    chk(1'b1, 8'hF0, 8'h06);
    @(posedge ref_clk);
    {s_busy, f_busy} <= 2'b00;
    repeat (4) @(posedge ref_clk);
    chk(1'b0, 8'hF0, 8'h02);
    // qualifiers on: both ports running
    @(posedge ref_clk);
    g_one <= 8'h01;
    g_six <= 8'h0C;
    wait_ctl(12'hFFF, 12'h303);
    // low power on the second port keeps access and contents
    i_host.wr_reg(1'b0, 8'hF0, 8'h00);
    wait_ctl(12'hFFF, 12'h309);
    chk(1'b0, 8'h70, 8'h5A);
    // call indicator still interrupts in low power; mask and clear
    i_host.wr_reg(1'b0, 8'hF9, 8'h01);
    @(posedge ref_clk);
    s_ci_n <= 1'b0;
    wait_ctl(12'h800, 12'h800);
    chk(1'b0, 8'hF8, 8'h01);
    i_host.wr_reg(1'b0, 8'hF9, 8'h00);
    wait_ctl(12'h800, 12'h000);
    i_host.wr_reg(1'b0, 8'hF9, 8'h01);
    wait_ctl(12'h800, 12'h800);
    i_host.wr_reg(1'b0, 8'hFA, 8'h01);
    wait_ctl(12'h800, 12'h000);
    chk(1'b0, 8'hF8, 8'h00);
    // the first port raises status bit 1 the same way
    i_host.wr_reg(1'b0, 8'hF9, 8'h02);
    f_ci_n <= 1'b0;
    wait_ctl(12'h800, 12'h800);
    chk(1'b1, 8'hF8, 8'h02);
    i_host.wr_reg(1'b0, 8'hFA, 8'h02);
    wait_ctl(12'h800, 12'h000);
    @(posedge ref_clk);
    {s_ci_n, f_ci_n} <= 2'b11;
    // extended access only with bank switching on; both ports ask
    {s_ext, f_ext} <= 2'b11;
    repeat (4) @(posedge ref_clk);
    wait_ctl(12'h0C0, 12'h000);
    i_host.wr_reg(1'b1, 8'hF0, 8'h82);
    wait_ctl(12'h0C0, 12'h040);
    i_host.wr_reg(1'b1, 8'hF0, 8'h02);
    wait_ctl(12'h0C0, 12'h000);
    // second port inactive: float on request, infrared tx always low
    @(posedge ref_clk);
    g_six <= 8'h08;
    i_host.wr_reg(1'b0, 8'hF0, 8'h01);
    wait_ctl(12'h622, 12'h420);
    i_host.wr_reg(1'b0, 8'hF0, 8'h00);
    wait_ctl(12'h622, 12'h400);
    @(posedge ref_clk);
    g_one <= 8'h00;
    wait_ctl(12'h100, 12'h000);
    // an unmapped index reads zero
    chk(1'b0, 8'h55, 8'h00);
    close_out();
  end
endmodule // sp_cfg_bank_tb
